// file: dv/gsa_core_test.sv
// Self-checking testbench for the gated sampling acquisition core
`timescale 1ns/1ps
module gsa_core_test;
  import gsa_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic gate_in = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0;
  logic slow = 1'b0;  // Host stalls when high
  logic pready, pslverr, mem_wr_en, strm_valid, strm_ready, acq_running;
  logic [31:0] prdata, mem_wr_addr;
  logic [15:0] mem_wr_data;
  logic [15:0] strm_data;  // Stream word offered to the host
  logic [31:0] rd;  // Last read data
  logic er;  // Last error response
  int err_count = 0;
  int compares = 0;
  int wcount = 0;  // Memory writes seen
  int k = 0;  // Samples sent this run
  int words, w0;
  // Illegal and boundary settings: mode, total, pre, channels, error expected
  logic [31:0] bm [7] = '{MODE_MEM, MODE_MEM, 32'h5, MODE_MEM, MODE_MEM, MODE_MEM, MODE_MEM};
  logic [31:0] bt [7] = '{32'h28, 32'h10, 32'h20, 32'h20, 32'h20, 32'h2000_0010, 32'h2000_0000};
  logic [31:0] bp [7] = '{32'h10, 32'h10, 32'h10, 32'h8, 32'h10, 32'h10, 32'h10};
  logic [1:0] bc [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h2};
  logic be [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  always #10 clk = ~clk;

  gsa_core dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gate_in(gate_in), .sample_valid(sample_valid), .sample_data(sample_data),
    .strm_ready(strm_ready), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .strm_valid(strm_valid), .strm_data(strm_data),
    .acq_running(acq_running));

  gsa_host_model host (.clk(clk), .rst_n(rst_n), .slow(slow), .strm_valid(strm_valid),
    .strm_ready(strm_ready), .words(words));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Compare and report
  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers ends the run through the same verdict
    if (n >= 50) begin
      check("pready", pready, 1'b1);
      report_and_stop();
    end
  endtask

  // Read a register and compare
  task rchk(input string name, input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  // Program a full configuration; sizes are single-word here
  task cfg(input logic [31:0] mode, input logic [31:0] tot, input logic [31:0] pre,
           input logic [31:0] lim);
    apb(1'b1, IDX_MODE, mode);
    apb(1'b1, IDX_TOTAL_LO, tot);
    apb(1'b1, IDX_TOTAL_HI, 32'h0);
    apb(1'b1, IDX_GATE_LIM, lim);
    apb(1'b1, IDX_PRE, pre);
    apb(1'b1, IDX_POST_LO, 32'h10);
    apb(1'b1, IDX_POST_HI, 32'h0);
  endtask

  // Start with a channel code; sample index restarts
  task start(input logic [1:0] ch);
    k = 0;
    apb(1'b1, IDX_CTRL, {28'h0, ch, 2'b01});
  endtask

  // One sample carrying its own index, then a gap
  task send(input logic g, input int gap);
    @(posedge clk);
    gate_in <= g;
    sample_valid <= 1'b1;
    sample_data <= k[15:0];
    @(posedge clk);
    sample_valid <= 0;
    k++;
    repeat (gap) @(posedge clk);
  endtask

  // Closing verdict
  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ************************************************************
  // Monitor: memory writes in order, two bytes apart
  // ************************************************************
  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) begin
      check("mem_wr_addr", mem_wr_addr, 2 * wcount);
      if (k >= 17) check("mem_wr_data", mem_wr_data, k - 17);
      wcount++;
    end
  end

  // Monitor: each drained stream word is the sample sixteen pushes older
  always @(posedge clk) begin
    if (strm_valid === 1'b1 && strm_ready === 1'b1 && k >= 17) begin
      check("strm_data", strm_data, k - 17);
    end
  end

  // Watchdog; the whole run needs well under this
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk("mode", IDX_MODE, RST_MODE);
    rchk("total_lo", IDX_TOTAL_LO, RST_TOTAL[31:0]);
    rchk("gate_lim", IDX_GATE_LIM, RST_GATE_LIM);
    rchk("pre", IDX_PRE, RST_PRE);
    rchk("post_lo", IDX_POST_LO, RST_POST[31:0]);
    apb(1'b0, 14'h0001, 32'h0);
    check("unmapped_err", er, 1'b1);
    // Memory mode: idle gate stores nothing, total count cuts the open gate
    cfg(MODE_MEM, 32'h20, 32'h10, 32'h0);
    start(2'h0);
    repeat (5) send(1'b0, 0);
    check("stored_idle", wcount, 0);
    repeat (40) send(1'b1, 0);
    repeat (4) @(posedge clk);
    check("writes", wcount, 32);
    check("running", acq_running, 1'b0);
    rchk("status", IDX_STATUS, 32'h8);
    rchk("stored", IDX_STORED, 32'h20);
    // Streaming with a gate limit; each gate gives 4 + pre + post words
    for (int lim = 1; lim <= 2; lim++) begin
      slow <= (lim == 1);
      cfg(MODE_STREAM, 32'h20, 32'h10, lim);
      w0 = words;
      start(2'h0);
      for (int g = 0; g < lim; g++) begin
        repeat (4) send(1'b1, 3);
        repeat (40) send(1'b0, 3);
      end
      check("gate_end", acq_running, 1'b0);
      rchk("gates", IDX_GATES, lim);
      check("words", words - w0, 36 * lim);
      repeat (4) send(1'b1, 3);
      check("words_after", words - w0, 36 * lim);
      apb(1'b0, IDX_STATUS, 32'h0);
      check("no_overrun", rd[2:0], 3'h0);
    end
    check("mem_writes", wcount, 32);
    // Unlimited streaming until a stop command; config locked meanwhile
    cfg(MODE_STREAM, 32'h20, 32'h10, 32'h0);
    start(2'h0);
    for (int g = 0; g < 3; g++) begin
      repeat (4) send(1'b1, 3);
      repeat (40) send(1'b0, 3);
    end
    check("unlimited", acq_running, 1'b1);
    apb(1'b1, IDX_MODE, MODE_MEM);
    rchk("mode_locked", IDX_MODE, MODE_STREAM);
    apb(1'b1, IDX_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    check("stopped", acq_running, 1'b0);
    // Illegal and boundary settings: illegal ones refused with an error flag, the last boundary one runs
    for (int i = 0; i < 7; i++) begin
      cfg(bm[i], bt[i], bp[i], 32'h0);
      start(bc[i]);
      apb(1'b0, IDX_STATUS, 32'h0);
      check("run_state", rd[1:0], be[i] ? 2'b10 : 2'b01);
      apb(1'b1, IDX_CTRL, 32'h2);
    end
    report_and_stop();
  end
endmodule

// file: dv/gsa_host_model.sv
// Host-side model that drains the streamed sample words
`timescale 1ns/1ps
module gsa_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic strm_valid,
  output logic strm_ready,
  output int words
);
  // ************************************************************
  // Draining
  // ************************************************************
  logic phase_ff;  // Stall phase, used only when slow

  // Count every word taken; toggle the stall phase each cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
      words <= 0;
    end else begin
      phase_ff <= ~phase_ff;
      if (strm_valid && strm_ready) begin
        words <= words + 1;
      end
    end
  end

  // Slow host takes a word only every other cycle, so the core sees back-pressure
  assign strm_ready = rst_n && (!slow || phase_ff);
endmodule

// file: hw/gsa_core.sv
// Gated sampling acquisition core with APB registers
// Operation
// - Store only inside gate windows, then pause
// - Memory mode stops at total count, mid-gate
// - Mode value 4 selects gated memory
// - Mode value 64 selects gated streaming
// - Total size sets samples stored in memory
// - Streaming ends by stop or gate limit
// - Gate limit zero runs until stopped
// - Nonzero gate limit ends after that many
// - Stream data continuously; host keeps draining
// - Each sample occupies two bytes of memory
// - Total maximum scales with channels and memory
// - Pre-gate count keeps samples before gate
// - Post-gate count adds samples after gate
`timescale 1ns/1ps
module gsa_core
  import gsa_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic gate_in,
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  input wire logic strm_ready,
  output logic mem_wr_en,
  output logic [31:0] mem_wr_addr,
  output logic [15:0] mem_wr_data,
  output logic strm_valid,
  output logic [15:0] strm_data,
  output logic acq_running
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [0:0] {GSA_IDLE, GSA_RUN} gsa_fsm_t;

  typedef struct packed {
    gsa_fsm_t st;            // Acquisition state
    logic [31:0] mode;       // Operating mode
    logic [63:0] total;      // Total samples for memory mode
    logic [31:0] gate_lim;   // Gates to capture, zero is endless
    logic [31:0] pre;        // Pre-gate samples
    logic [63:0] post;       // Post-gate samples
    logic [1:0] chsel;       // Channels: 0=1, 1=2, 2=4
    logic pready;            // APB answer
    logic pslverr;           // Unmapped access
    logic [31:0] prdata;     // Read data
    logic cfg_err;           // Last start refused
    logic overrun;           // Stream sample lost
    logic done;              // Acquisition finished
    logic [63:0] tail;       // Samples left after gate falls
    logic [63:0] stored;     // Samples taken this run
    logic [31:0] gates;      // Gate windows completed
    logic mem_we;            // Memory write pulse
    logic [31:0] mem_addr;   // Byte address
    logic [15:0] mem_data;
    logic s_valid;           // Stream word pending
    logic [15:0] s_data;
  } gsa_state_t;

  gsa_state_t cur_ff;
  gsa_state_t nxt_cur;

  gsa_dly_if dly ();

  logic [13:0] idx;        // Word index of the access
  logic apb_wr;            // Write takes effect this edge
  logic running;
  logic rec_now;           // Sample falls inside a window
  logic seg_end;           // Last sample of a window
  logic start_cmd;
  logic stop_cmd;
  logic cfg_ok;
  logic [1:0] new_ch;
  logic [63:0] max_total;

  assign idx = paddr[15:2];
  assign apb_wr = psel && penable && cur_ff.pready && pwrite;
  assign running = (cur_ff.st == GSA_RUN);
  assign start_cmd = apb_wr && (idx == IDX_CTRL) && pwdata[CTRL_START_BIT];
  assign stop_cmd = apb_wr && (idx == IDX_CTRL) && pwdata[CTRL_STOP_BIT];
  assign new_ch = pwdata[CTRL_CH_LSB+1:CTRL_CH_LSB];

  // Window: gate true, or pre plus post samples still owed after it
  assign rec_now = running && sample_valid && (gate_in || (cur_ff.tail != 64'h0));
  assign seg_end = running && sample_valid && !gate_in && (cur_ff.tail == 64'h1);

  // ************************************************************
  // History line hookup
  // ************************************************************
  // Fed while idle too, so the first gate already has its history
  assign dly.push = sample_valid;
  assign dly.din = sample_data;
  assign dly.depth = cur_ff.pre[13:0];

  gsa_delay_line u_dly (
    .clk(clk),
    .rst_n(rst_n),
    .dl(dly.line)
  );

  // ************************************************************
  // Configuration check at start
  // ************************************************************
  // Reject instead of truncating: a clipped size would silently shift data
  always_comb begin
    max_total = MEM_SAMPLES >> new_ch;
    cfg_ok = (new_ch != CH_ILLEGAL);
    cfg_ok = cfg_ok && ((cur_ff.mode == MODE_MEM) || (cur_ff.mode == MODE_STREAM));
    cfg_ok = cfg_ok && (cur_ff.pre >= PRE_MIN) && (cur_ff.pre <= PRE_MAX);
    cfg_ok = cfg_ok && ((cur_ff.pre[3:0] & STEP_MASK) == 4'h0);
    cfg_ok = cfg_ok && (cur_ff.post >= POST_MIN) && (cur_ff.post <= POST_MAX);
    cfg_ok = cfg_ok && ((cur_ff.post[3:0] & STEP_MASK) == 4'h0);
    if (cur_ff.mode == MODE_MEM) begin
      // Total size only matters in memory mode
      cfg_ok = cfg_ok && (cur_ff.total >= TOTAL_MIN) && (cur_ff.total <= max_total);
      cfg_ok = cfg_ok && ((cur_ff.total[3:0] & STEP_MASK) == 4'h0);
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.mem_we = 1'b0;
    // APB: answer in the first access cycle, one wait-free transfer
    nxt_cur.pready = psel && !penable && !cur_ff.pready;
    if (psel && !penable) begin
      nxt_cur.pslverr = 1'b0;
      unique case (idx)
        IDX_MODE: nxt_cur.prdata = cur_ff.mode;
        IDX_TOTAL_LO: nxt_cur.prdata = cur_ff.total[31:0];
        IDX_TOTAL_HI: nxt_cur.prdata = cur_ff.total[63:32];
        IDX_GATE_LIM: nxt_cur.prdata = cur_ff.gate_lim;
        IDX_PRE: nxt_cur.prdata = cur_ff.pre;
        IDX_POST_LO: nxt_cur.prdata = cur_ff.post[31:0];
        IDX_POST_HI: nxt_cur.prdata = cur_ff.post[63:32];
        IDX_CTRL: nxt_cur.prdata = {28'h0, cur_ff.chsel, 2'h0};
        IDX_STATUS: nxt_cur.prdata = {28'h0, cur_ff.done, cur_ff.overrun,
                                      cur_ff.cfg_err, running};
        IDX_STORED: nxt_cur.prdata = cur_ff.stored[31:0];
        IDX_GATES: nxt_cur.prdata = cur_ff.gates;
        default: begin
          // Unmapped word: zero data and an error answer
          nxt_cur.prdata = 32'h0;
          nxt_cur.pslverr = 1'b1;
        end
      endcase
      if (!pwrite) begin
        nxt_cur.prdata = nxt_cur.prdata;
      end else begin
        nxt_cur.prdata = 32'h0;
      end
    end

    // Configuration writes are held off while running
    if (apb_wr && !running) begin
      unique case (idx)
        IDX_MODE: nxt_cur.mode = pwdata;
        IDX_TOTAL_LO: nxt_cur.total[31:0] = pwdata;
        IDX_TOTAL_HI: nxt_cur.total[63:32] = pwdata;
        IDX_GATE_LIM: nxt_cur.gate_lim = pwdata;
        IDX_PRE: nxt_cur.pre = pwdata;
        IDX_POST_LO: nxt_cur.post[31:0] = pwdata;
        IDX_POST_HI: nxt_cur.post[63:32] = pwdata;
        IDX_CTRL: nxt_cur.chsel = new_ch;
        default: nxt_cur.chsel = cur_ff.chsel;
      endcase
    end

    // Stream hand-off: word leaves when the host takes it
    if (cur_ff.s_valid && strm_ready) begin
      nxt_cur.s_valid = 1'b0;
    end

    unique case (cur_ff.st)
      GSA_IDLE: begin
        if (start_cmd) begin
          nxt_cur.cfg_err = !cfg_ok;
          if (cfg_ok) begin
            nxt_cur.st = GSA_RUN;
            nxt_cur.done = 1'b0;
            nxt_cur.overrun = 1'b0;
            nxt_cur.stored = 64'h0;
            nxt_cur.gates = 32'h0;
            nxt_cur.tail = 64'h0;
          end
        end
      end
      GSA_RUN: begin
        if (sample_valid) begin
          // Gate reloads pre+post; after it falls the tail counts down
          if (gate_in) begin
            nxt_cur.tail = {32'h0, cur_ff.pre} + cur_ff.post;
          end else if (cur_ff.tail != 64'h0) begin
            nxt_cur.tail = cur_ff.tail - 64'h1;
          end
        end
        if (rec_now) begin
          nxt_cur.stored = cur_ff.stored + 64'h1;
          if (cur_ff.mode == MODE_MEM) begin
            nxt_cur.mem_we = 1'b1;
            nxt_cur.mem_addr = cur_ff.stored[31:0] << SAMPLE_SHIFT;
            nxt_cur.mem_data = dly.dout;
            if (cur_ff.stored + 64'h1 == cur_ff.total) begin
              // Size counter cuts the window short, gate or not
              nxt_cur.st = GSA_IDLE;
              nxt_cur.done = 1'b1;
            end
          end else begin
            // A word the host has not drained is lost and flagged
            if (cur_ff.s_valid && !strm_ready) begin
              nxt_cur.overrun = 1'b1;
            end
            nxt_cur.s_valid = 1'b1;
            nxt_cur.s_data = dly.dout;
          end
        end
        if (seg_end) begin
          nxt_cur.gates = cur_ff.gates + 32'h1;
          if ((cur_ff.mode == MODE_STREAM) && (cur_ff.gate_lim != 32'h0) &&
              (cur_ff.gates + 32'h1 == cur_ff.gate_lim)) begin
            nxt_cur.st = GSA_IDLE;
            nxt_cur.done = 1'b1;
          end
        end
        if (stop_cmd) begin
          nxt_cur.st = GSA_IDLE;
          nxt_cur.done = 1'b1;
        end
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.st <= GSA_IDLE;
      cur_ff.mode <= RST_MODE;
      cur_ff.total <= RST_TOTAL;
      cur_ff.gate_lim <= RST_GATE_LIM;
      cur_ff.pre <= RST_PRE;
      cur_ff.post <= RST_POST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pready = cur_ff.pready;
  assign prdata = cur_ff.prdata;
  assign pslverr = cur_ff.pslverr;
  assign mem_wr_en = cur_ff.mem_we;
  assign mem_wr_addr = cur_ff.mem_addr;
  assign mem_wr_data = cur_ff.mem_data;
  assign strm_valid = cur_ff.s_valid;
  assign strm_data = cur_ff.s_data;
  assign acq_running = running;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_idle_two;
    !running ##1 !running;
  endsequence

  sequence s_last_mem;
    rec_now && (cur_ff.mode == MODE_MEM) && (cur_ff.stored + 64'h1 == cur_ff.total);
  endsequence

  a_idle_no_store: assert property (
    s_idle_two |-> !mem_wr_en && !(strm_valid && !$past(strm_valid)))
    else $error("store while idle");

  a_std_size_stop: assert property (
    s_last_mem |=> !acq_running && mem_wr_en ##1 !mem_wr_en)
    else $error("memory mode missed its total");

  a_mode_mem_sel: assert property (
    apb_wr && !running && idx == IDX_MODE && pwdata == MODE_MEM
    |=> cur_ff.mode == MODE_MEM)
    else $error("memory mode not taken");

  a_mode_strm_sel: assert property (
    apb_wr && !running && idx == IDX_MODE && pwdata == MODE_STREAM
    |=> cur_ff.mode == MODE_STREAM)
    else $error("stream mode not taken");

  a_gate_lim_stop: assert property (
    seg_end && cur_ff.mode == MODE_STREAM && cur_ff.gate_lim != 32'h0 &&
    cur_ff.gates + 32'h1 == cur_ff.gate_lim |=> !acq_running && cur_ff.done)
    else $error("gate limit ignored");

  a_endless_run: assert property (
    running && cur_ff.mode == MODE_STREAM && cur_ff.gate_lim == 32'h0 && !stop_cmd
    |=> acq_running)
    else $error("endless stream stopped");

  a_stop_cmd: assert property (
    running && stop_cmd |=> !acq_running && cur_ff.done)
    else $error("stop ignored");

  a_two_byte_addr: assert property (
    mem_wr_en |-> mem_wr_addr == ((cur_ff.stored[31:0] - 32'h1) << SAMPLE_SHIFT))
    else $error("address not in two-byte units");

  a_stream_feed: assert property (
    rec_now && cur_ff.mode == MODE_STREAM |=> strm_valid && strm_data == $past(dly.dout))
    else $error("stream word missing");

  a_bad_cfg: assert property (
    !running && start_cmd && !cfg_ok |=> !acq_running && cur_ff.cfg_err)
    else $error("illegal setting accepted");

endmodule

// file: hw/gsa_delay_line.sv
// Pre-gate history line: delays the sample stream by a programmable depth
`timescale 1ns/1ps
module gsa_delay_line
  import gsa_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  gsa_dly_if.line dl
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DLY_AW-1:0] wr_ptr;  // Next slot to fill
  } gsa_dly_state_t;

  gsa_dly_state_t cur_ff;
  gsa_dly_state_t nxt_cur;
  logic [15:0] hist [DLY_DEPTH];  // Sample history, no reset needed
  logic [DLY_AW-1:0] rd_idx;

  // Read before write: a depth of 8192 reads the slot about to be replaced
  assign rd_idx = cur_ff.wr_ptr - dl.depth[DLY_AW-1:0];
  assign dl.dout = hist[rd_idx];

  // Pointer advance
  always_comb begin
    nxt_cur = cur_ff;
    if (dl.push) begin
      nxt_cur.wr_ptr = cur_ff.wr_ptr + 13'h1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // History storage, kept out of reset so it maps to block memory
  always_ff @(posedge clk) begin
    if (dl.push) begin
      hist[cur_ff.wr_ptr] <= dl.din;
    end
  end

endmodule

// file: hw/gsa_dly_if.sv
// Interface between the acquisition core and its pre-gate history line
`timescale 1ns/1ps
interface gsa_dly_if;
  logic push;          // One sample enters the line
  logic [15:0] din;    // Sample entering
  logic [13:0] depth;  // Delay in samples
  logic [15:0] dout;   // Sample that entered depth pushes ago
  modport owner (output push, output din, output depth, input dout);
  modport line (input push, input din, input depth, output dout);
endinterface

// file: hw/gsa_pkg.sv
// Package of constants for the gated sampling acquisition block
package gsa_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [13:0] IDX_MODE = 14'h251c;      // Operating mode
  localparam logic [13:0] IDX_TOTAL_LO = 14'h2710;  // Total sample count, low word
  localparam logic [13:0] IDX_TOTAL_HI = 14'h2711;  // Total sample count, high word
  localparam logic [13:0] IDX_GATE_LIM = 14'h2724;  // Gate count limit
  localparam logic [13:0] IDX_PRE = 14'h272e;       // Pre-gate samples
  localparam logic [13:0] IDX_POST_LO = 14'h2774;   // Post-gate samples, low word
  localparam logic [13:0] IDX_POST_HI = 14'h2775;   // Post-gate samples, high word
  localparam logic [13:0] IDX_CTRL = 14'h27d8;      // Start, stop, channel select
  localparam logic [13:0] IDX_STATUS = 14'h27d9;    // Running and flags
  localparam logic [13:0] IDX_STORED = 14'h27da;    // Samples stored, low word
  localparam logic [13:0] IDX_GATES = 14'h27db;     // Gates completed

  // ************************************************************
  // Field positions and encodings
  // ************************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CH_LSB = 2;
  localparam logic [31:0] MODE_MEM = 32'h0000_0004;     // gated_memory_mode
  localparam logic [31:0] MODE_STREAM = 32'h0000_0040;  // gated_streaming_mode
  localparam logic [1:0] CH_ILLEGAL = 2'h3;             // 1, 2, 4 channels only

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_MODE = 32'h0000_0004;
  localparam logic [63:0] RST_TOTAL = 64'h0000_0000_0000_0020;
  localparam logic [31:0] RST_GATE_LIM = 32'h0000_0000;
  localparam logic [31:0] RST_PRE = 32'h0000_0010;
  localparam logic [63:0] RST_POST = 64'h0000_0000_0000_0010;

  // ************************************************************
  // Limits, all in samples
  // ************************************************************
  localparam logic [3:0] STEP_MASK = 4'hf;                        // Step of 16
  localparam logic [63:0] TOTAL_MIN = 64'h0000_0000_0000_0020;
  localparam logic [63:0] MEM_SAMPLES = 64'h0000_0000_8000_0000;  // Installed memory
  localparam logic [31:0] PRE_MIN = 32'h0000_0010;
  localparam logic [31:0] PRE_MAX = 32'h0000_2000;                // 8k
  localparam logic [63:0] POST_MIN = 64'h0000_0000_0000_0010;
  localparam logic [63:0] POST_MAX = 64'h0000_0001_ffff_fff0;     // 8G - 16
  localparam int SAMPLE_SHIFT = 1;                                // Two bytes per sample

  // ************************************************************
  // Pre-gate history line
  // ************************************************************
  localparam int DLY_AW = 13;
  localparam int DLY_DEPTH = 8192;

endpackage
